/* File: verilog/crc_engine_consts.vh */
// Constants for the byte-fed CRC engine and its special function register port
// What this block does
// - Poly select clear gives a 32-bit result with polynomial 0x04C11DB7, set gives 16-bit with 0x1021.
// - Writing one to control bit 3 loads the whole internal result with the chosen init value.
// - Init value select 0 loads all zeros, 1 loads all ones.
// - Control bits 1:0 hold the result byte pointer, which advances after every data port access.
// - In 32-bit mode pointer 00 picks bits 7:0, 01 picks bits 15:8, 11 picks bits 31:24.
// - In 16-bit mode pointers 00 and 10 pick bits 7:0, pointers 01 and 11 pick bits 15:8.
// - Each byte written to the data input register is folded into the result by the selected algorithm.
// - A data port read returns the pointed result byte and a write overwrites that byte.
// - Control bits 7:5 read as zero and ignore writes.
// - The 16-bit CRC xors the byte into the high result byte, then shifts left 8 times xoring 0x1021 on carry.
// - The 32-bit CRC xors the byte into the low result byte, then shifts right 8 times xoring 0xEDB88320 on carry.
// - The result holds until reinitialised, overwritten through the port, or updated by an input byte.
`ifndef CRC_ENGINE_CONSTS_VH
`define CRC_ENGINE_CONSTS_VH

// Register addresses
`define ADDR_CONTROL 8'h91
`define ADDR_INPUT 8'h94
`define ADDR_RESULT 8'hd9

// Control field positions
`define CTL_POLY_BIT 4
`define CTL_INIT_BIT 3
`define CTL_VAL_BIT 2
`define CTL_PTR_HI 1
`define CTL_PTR_LO 0

// Reset and init values
`define CONTROL_RESET 8'h00
`define BYTE_RESET 8'h00
`define RESULT_ZERO 32'h00000000
`define RESULT_ONES 32'hffffffff

// Polynomials
`define POLY16 16'h1021
`define POLY32_REFLECTED 32'hedb88320
`define BITS_PER_BYTE 8

// Pointer codes
`define PTR_B0 2'h0
`define PTR_B1 2'h1
`define PTR_B2 2'h2
`define PTR_B3 2'h3

`endif

/* File: verilog/crc_engine_register_port.v */
// CRC engine reached through three special function registers
`timescale 1ns/1ps
`include "crc_engine_consts.vh"

module crc_engine_register_port
(
   // Clock and reset
   input wire i_clock,
   input wire i_reset,
   // Special function register bus from the core
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_write,
   input wire i_sfr_read,
   input wire [7:0] i_sfr_wdata,
   // Read data, registered one cycle after the read strobe
   output reg [7:0] o_sfr_rdata,
   output reg o_sfr_rvalid
);

   // Control fields
   reg poly_select_q;
   reg init_value_select_q;
   reg [1:0] result_byte_pointer_q;
   reg [7:0] input_byte_q;
   reg [31:0] result_q;

   // Decoded strobes
   wire wr_ctl = i_sfr_write && (i_sfr_addr == `ADDR_CONTROL);
   wire wr_in = i_sfr_write && (i_sfr_addr == `ADDR_INPUT);
   wire wr_res = i_sfr_write && (i_sfr_addr == `ADDR_RESULT);
   wire rd_res = i_sfr_read && (i_sfr_addr == `ADDR_RESULT);

   // Byte lane selected by the pointer; 16-bit mode folds pointer bit 1 away
   reg [1:0] lane;
   always @*
   begin
      if (poly_select_q)
         lane = {1'b0, result_byte_pointer_q[0]};
      else
         lane = result_byte_pointer_q;
   end

   // Pointed result byte
   reg [7:0] lane_byte;
   always @*
   begin
      case (lane)
         `PTR_B0: lane_byte = result_q[7:0];
         `PTR_B1: lane_byte = result_q[15:8];
         `PTR_B2: lane_byte = result_q[23:16];
         `PTR_B3: lane_byte = result_q[31:24];
         default: lane_byte = result_q[7:0];
      endcase
   end

   // Whole byte folded in one cycle; unrolled bit loop keeps the core never waiting
   reg [15:0] c16;
   reg [31:0] c32;
   integer k;
   always @*
   begin
      c16 = result_q[15:0] ^ {i_sfr_wdata, 8'h00};
      c32 = result_q ^ {24'h000000, i_sfr_wdata};
      for (k = 0; k < `BITS_PER_BYTE; k = k + 1)
      begin
         if (c16[15])
            c16 = {c16[14:0], 1'b0} ^ `POLY16;
         else
            c16 = {c16[14:0], 1'b0};
         if (c32[0])
            c32 = {1'b0, c32[31:1]} ^ `POLY32_REFLECTED;
         else
            c32 = {1'b0, c32[31:1]};
      end
   end

   // Control register and pointer; port access advances pointer after control write
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         poly_select_q <= 1'b0;
         init_value_select_q <= 1'b0;
         result_byte_pointer_q <= `PTR_B0;
      end
      else if (wr_ctl)
      begin
         poly_select_q <= i_sfr_wdata[`CTL_POLY_BIT];
         init_value_select_q <= i_sfr_wdata[`CTL_VAL_BIT];
         result_byte_pointer_q <= i_sfr_wdata[`CTL_PTR_HI:`CTL_PTR_LO];
      end
      else if (wr_res || rd_res)
      begin
         result_byte_pointer_q <= result_byte_pointer_q + 2'h1;
      end
   end

   // Data input register keeps the last byte for read back
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         input_byte_q <= `BYTE_RESET;
      else if (wr_in)
         input_byte_q <= i_sfr_wdata;
   end

   // Result register; init bit takes the select value written in the same byte
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         result_q <= `RESULT_ZERO;
      else if (wr_ctl && i_sfr_wdata[`CTL_INIT_BIT])
      begin
         if (i_sfr_wdata[`CTL_VAL_BIT])
            result_q <= `RESULT_ONES;
         else
            result_q <= `RESULT_ZERO;
      end
      else if (wr_in)
      begin
         if (poly_select_q)
            result_q <= {result_q[31:16], c16};
         else
            result_q <= c32;
      end
      else if (wr_res)
      begin
         case (lane)
            `PTR_B0: result_q[7:0] <= i_sfr_wdata;
            `PTR_B1: result_q[15:8] <= i_sfr_wdata;
            `PTR_B2: result_q[23:16] <= i_sfr_wdata;
            `PTR_B3: result_q[31:24] <= i_sfr_wdata;
            default: result_q[7:0] <= i_sfr_wdata;
         endcase
      end
      // Otherwise the result simply holds
   end

   // Read mux; unmapped addresses read as zero
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_sfr_rdata <= `BYTE_RESET;
         o_sfr_rvalid <= 1'b0;
      end
      else
      begin
         o_sfr_rvalid <= i_sfr_read;
         if (!i_sfr_read)
            o_sfr_rdata <= `BYTE_RESET;
         else if (i_sfr_addr == `ADDR_CONTROL)
            o_sfr_rdata <= {3'h0, poly_select_q, 1'b0, init_value_select_q,
               result_byte_pointer_q};
         else if (i_sfr_addr == `ADDR_INPUT)
            o_sfr_rdata <= input_byte_q;
         else if (rd_res)
            o_sfr_rdata <= lane_byte;
         else
            o_sfr_rdata <= `BYTE_RESET;
      end
   end

endmodule // crc_engine_register_port

/* File: dv/crc_core_model.sv */
// Core-side bus master for the CRC registers
`timescale 1ns/1ps
module crc_core_model
(
   // Clock and read data
   input wire i_clock,
   input wire [7:0] i_rdata,
   // Register bus
   output reg [7:0] o_addr = 8'h00,
   output reg o_write = 1'b0,
   output reg o_read = 1'b0,
   output reg [7:0] o_wdata = 8'h00
);
   // Write strobe stays up; the next call replaces it
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge i_clock);
         o_write <= 1'b1;
         o_read <= 1'b0;
         o_addr <= a;
         o_wdata <= d;
      end
   endtask
   // Read, then release with scrambled lines
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge i_clock);
         o_write <= 1'b0;
         o_read <= 1'b1;
         o_addr <= a;
         @(posedge i_clock);
         o_read <= 1'b0;
         o_addr <= ~a;
         o_wdata <= ~o_wdata;
         #1 d = i_rdata;
      end
   endtask
endmodule // crc_core_model

/* File: dv/crc_engine_register_port_asserts.sv */
// Port checker for the CRC register block
`timescale 1ns/1ps
module crc_engine_register_port_asserts
(
   input wire i_clock,
   input wire i_reset,
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_write,
   input wire i_sfr_read,
   input wire [7:0] i_sfr_wdata,
   input wire [7:0] o_sfr_rdata,
   input wire o_sfr_rvalid
);
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_reset);
   // Decoded single-cycle accesses
   wire wc = i_sfr_write && i_sfr_addr == 8'h91;
   wire wi = i_sfr_write && i_sfr_addr == 8'h94;
   wire pa = (i_sfr_write || i_sfr_read) && i_sfr_addr == 8'hd9;
   wire rd = i_sfr_read && !i_sfr_write;
   wire rc = rd && i_sfr_addr == 8'h91;
   wire ri = rd && i_sfr_addr == 8'h94;
   wire rp = rd && pa;
   property p_rv; i_sfr_read |=> o_sfr_rvalid; endproperty
   a_rv: assert property (p_rv) else $error("read valid missing");
   property p_nr; !i_sfr_read |=> !o_sfr_rvalid && o_sfr_rdata == 8'h00; endproperty
   a_nr: assert property (p_nr) else $error("read data without read");
   property p_un; rd && !(rc || ri || rp) |=> o_sfr_rdata == 8'h00; endproperty
   a_un: assert property (p_un) else $error("unmapped read not zero");
   property p_ct; wc ##1 rc |=> o_sfr_rdata == ($past(i_sfr_wdata, 2) & 8'h17); endproperty
   a_ct: assert property (p_ct) else $error("control readback wrong");
   property p_in; wi ##1 ri |=> o_sfr_rdata == $past(i_sfr_wdata, 2); endproperty
   a_in: assert property (p_in) else $error("input readback wrong");
   property p_it; (wc && i_sfr_wdata[3]) ##1 rp |=> o_sfr_rdata == {8{$past(i_sfr_wdata[2], 2)}}; endproperty
   a_it: assert property (p_it) else $error("init value wrong");
   property p_pt; wc ##1 pa ##1 rc |=> o_sfr_rdata[1:0] == $past(i_sfr_wdata[1:0], 3) + 2'h1; endproperty
   a_pt: assert property (p_pt) else $error("pointer not advanced");
   property p_ex; (wc && i_sfr_wdata == 8'h1c) ##1 (wi && i_sfr_wdata == 8'h63) ##1 rp |=> o_sfr_rdata == 8'h35; endproperty
   a_ex: assert property (p_ex) else $error("16-bit fold wrong");
endmodule // crc_engine_register_port_asserts
bind crc_engine_register_port crc_engine_register_port_asserts chk (.*);

/* File: dv/crc_engine_register_port_test.sv */
// Self-checking bench for the CRC register block
`timescale 1ns/1ps
module crc_engine_register_port_test;
   reg i_clock = 1'b0;
   reg i_reset = 1'b1;
   wire [7:0] a, wd, rdt;
   wire w, r, v;
   integer error_cnt = 0;
   integer cmp_count = 0;
   integer k;
   reg [7:0] d;
   always #2 i_clock = ~i_clock;
   crc_engine_register_port DUT (.i_clock(i_clock), .i_reset(i_reset), .i_sfr_addr(a),
      .i_sfr_write(w), .i_sfr_read(r), .i_sfr_wdata(wd), .o_sfr_rdata(rdt), .o_sfr_rvalid(v));
   crc_core_model m (.i_clock(i_clock), .i_rdata(rdt), .o_addr(a), .o_write(w), .o_read(r),
      .o_wdata(wd));
   task chk(input [7:0] s, input [7:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (s !== e)
         begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
         end
      end
   endtask
   task end_sim;
      begin
         $display("errors %0d compares %0d", error_cnt, cmp_count);
         if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Unmapped addresses 55, aa, 54 and a8 read zero after reset
   task t_reset;
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            m.rd(8'h55 << k, d);
            chk(d, 8'h00);
         end
      end
   endtask
   // Init, fold bytes n from s, read all four pointer slots
   task t_crc(input [7:0] c, input integer s, input integer n, input [31:0] e);
      integer i;
      begin
         m.wr(8'h91, c);
         for (i = s; i < s + n; i = i + 1)
            m.wr(8'h94, 32'h63aabbcc >> (24 - 8 * i));
         for (i = 0; i < 4; i = i + 1)
         begin
            m.rd(8'hd9, d);
            chk(d, e >> (8 * (c[4] ? i % 2 : i)));
         end
      end
   endtask
   // Reserved bits, port writes and pointer wrap
   task t_port;
      begin
         m.wr(8'h94, 8'h3c);
         m.rd(8'h94, d);
         chk(d, 8'h3c);
         m.wr(8'h91, 8'he2);
         m.rd(8'h91, d);
         chk(d, 8'h02);
         chk({7'h00, v}, 8'h01);
         m.wr(8'h91, 8'h03);
         m.wr(8'hd9, 8'ha5);
         m.rd(8'h91, d);
         chk(d, 8'h00);
         m.wr(8'hd9, 8'h5a);
         m.wr(8'h91, 8'h03);
         m.rd(8'hd9, d);
         chk(d, 8'ha5);
         m.rd(8'hd9, d);
         chk(d, 8'h5a);
      end
   endtask
   // Cut a hang short
   initial
   begin
      #20000;
      error_cnt = error_cnt + 1;
      end_sim;
   end
   initial
   begin
      @(posedge i_clock);
      @(posedge i_clock);
      i_reset <= 1'b0;
      t_reset;
      t_crc(8'h1c, 0, 1, 32'hbd35);
      t_crc(8'h0c, 0, 1, 32'hf9462090);
      t_crc(8'h1c, 1, 3, 32'h6cf6);
      t_crc(8'h0c, 1, 3, 32'h41b207b3);
      t_crc(8'h08, 0, 0, 32'h0);
      t_port;
      end_sim;
   end
endmodule // crc_engine_register_port_test
